/* File: adc_seq_defs.svh */
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// Word addresses of the registers on the register bus
`define OFF_CONTROL_0    4'h0
`define OFF_CONTROL_1    4'h1
`define OFF_RESULT_HIGH  4'h2
`define OFF_RESULT_LOW   4'h3
`define OFF_IRQ_STATUS   4'h4
`define OFF_IRQ_MASK     4'h5

// Field positions in control word 0
`define BIT_JUSTIFY      7
`define BIT_REFERENCE    6
`define BIT_START        1
`define BIT_ENABLE       0
`define CHAN_HI          4
`define CHAN_LO          2
// Field position in control word 1
`define CLKSEL_HI        6
`define CLKSEL_LO        4

// Reset values
`define CONTROL_0_RST    8'h00
`define CONTROL_1_RST    3'h0

// Timing counts in bit conversion periods
`define CONV_PERIODS     4'd11
`define ABORT_PERIODS    4'd2
`define RESULT_BITS      10

// Internal oscillator limit and derived divide in system clocks
`define CLK_HZ           25000000
`define RC_OSC_MAX_HZ    500000
`define RC_DIV           ((`CLK_HZ + `RC_OSC_MAX_HZ - 1) / `RC_OSC_MAX_HZ)

`endif

/* File: adc_seq_pkg.sv */
package adc_seq_pkg;

	// Conversion sequencer states, Gray coded along idle-convert-abort
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_CONVERT = 2'b01,
		ST_ABORT   = 2'b11
	} conv_state_t;

	// Settings handed to the analog sampler
	typedef struct packed {
		logic       enable;
		logic       reference;
		logic [2:0] channel;
		logic       sample;
		logic       hold;
	} analog_ctl_t;

endpackage : adc_seq_pkg

/* File: adc_sequencer_regs.sv */
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`include "adc_seq_defs.svh"

// How it works
// - Justify bit set gives right-justified result, clear gives left.
// - Reference bit set picks the external pin, clear picks supply.
// - Three-bit channel field routes inputs zero to seven to the sampler.
// - Writing one to start bit converts; reads one until done.
// - Enable bit clear turns the converter fully off.
// - Clock field picks system divide 2..64 or internal oscillator.
// - Left format: high holds bits 9..2, low top two hold 1..0.
// - Right format: high low two hold 9..8, low holds 7..0.
// - Unimplemented control bits read as zero.
// - Result is a ten-bit code of 1024 steps.
// - On completion clear start bit, set flag, load the result.
// - A conversion takes eleven bit conversion periods.
// - Early abort keeps old result and waits two periods.
module adc_sequencer_regs (
	// Clock and reset
	input  wire logic                     i_clk,
	input  wire logic                     i_rst,
	// Avalon-MM slave
	input  wire logic [3:0]               i_address,
	input  wire logic                     i_read,
	input  wire logic                     i_write,
	input  wire logic [31:0]              i_writedata,
	output logic      [31:0]              o_readdata,
	output logic                          o_waitrequest,
	// Analog sampler and comparator
	input  wire logic                     i_cmp_out,
	output adc_seq_pkg::analog_ctl_t      o_analog,
	output logic      [9:0]               o_dac_code,
	// Interrupt
	output logic                          o_irq
);
	import adc_seq_pkg::*;

	localparam int NB = `RESULT_BITS;

	conv_state_t state_r, state_nxt;
	logic [7:0]  ctl0_r, ctl0_nxt;
	logic [2:0]  clk_sel_r, clk_sel_nxt;
	logic [9:0]  result_r, result_nxt;
	logic [9:0]  sar_r, sar_nxt;
	logic [3:0]  per_r, per_nxt;
	logic        flag_r, flag_nxt;
	logic        mask_r, mask_nxt;
	logic        resp_r, resp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic        tick;
	logic        wr_acc, rd_acc;
	logic        abort_req, start_req;
	logic        tick_run;

	// Tick source for the bit conversion period
	adc_tick_gen u_tick (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_run     (tick_run),
		.i_clk_sel (clk_sel_r),
		.o_tick    (tick)
	);

	// Every access takes one wait cycle so read data come from a flop
	assign o_waitrequest = (i_read | i_write) & ~resp_r;
	assign wr_acc        = i_write & resp_r;
	assign rd_acc        = i_read & resp_r;

	// Start and abort requests from writes to control word 0
	assign start_req = wr_acc && i_address == `OFF_CONTROL_0
		&& i_writedata[`BIT_START] && i_writedata[`BIT_ENABLE];
	assign abort_req = wr_acc && i_address == `OFF_CONTROL_0
		&& !(i_writedata[`BIT_START] && i_writedata[`BIT_ENABLE]);
	// Abort restarts the period count so the settle lasts two whole periods
	assign tick_run  = state_r != ST_IDLE
		&& !(state_r == ST_CONVERT && abort_req);

	// Sequencer, result and register next-state logic
	always_comb begin
		state_nxt   = state_r;
		ctl0_nxt    = ctl0_r;
		clk_sel_nxt = clk_sel_r;
		result_nxt  = result_r;
		sar_nxt     = sar_r;
		per_nxt     = per_r;
		flag_nxt    = flag_r;
		mask_nxt    = mask_r;
		resp_nxt    = (i_read | i_write) & ~resp_r;
		// Software writes
		if (wr_acc) begin
			unique case (i_address)
				`OFF_CONTROL_0: begin
					ctl0_nxt = i_writedata[7:0] & 8'hDF;
				end
				`OFF_CONTROL_1: begin
					clk_sel_nxt = i_writedata[`CLKSEL_HI:`CLKSEL_LO];
				end
				`OFF_RESULT_HIGH: begin
					if (ctl0_r[`BIT_JUSTIFY]) begin
						result_nxt[9:8] = i_writedata[1:0];
					end else begin
						result_nxt[9:2] = i_writedata[7:0];
					end
				end
				`OFF_RESULT_LOW: begin
					if (ctl0_r[`BIT_JUSTIFY]) begin
						result_nxt[7:0] = i_writedata[7:0];
					end else begin
						result_nxt[1:0] = i_writedata[7:6];
					end
				end
				`OFF_IRQ_STATUS: begin
					if (i_writedata[0]) flag_nxt = 1'b0;
				end
				`OFF_IRQ_MASK: begin
					mask_nxt = i_writedata[0];
				end
				default: begin
				end
			endcase
		end
		// Start bit without enable cannot run
		if (!ctl0_nxt[`BIT_ENABLE]) begin
			ctl0_nxt[`BIT_START] = 1'b0;
		end
		unique case (state_r)
			ST_IDLE: begin
				if (start_req) begin
					state_nxt = ST_CONVERT;
					sar_nxt   = 10'h200;
					per_nxt   = 4'h0;
				end
			end
			ST_CONVERT: begin
				if (abort_req || !ctl0_nxt[`BIT_ENABLE]) begin
					// Old result kept; settle before next acquisition
					state_nxt = ST_ABORT;
					per_nxt   = 4'h0;
				end else if (tick) begin
					per_nxt = per_r + 4'h1;
					if (per_r >= 4'h1 && per_r <= 4'(NB)) begin
						// One bit resolved per period, MSB first
						sar_nxt = sar_r;
						if (!i_cmp_out) begin
							sar_nxt[4'(NB) - per_r] = 1'b0;
						end
						if (per_r != 4'(NB)) begin
							sar_nxt[4'(NB) - per_r - 4'h1] = 1'b1;
						end
					end
					if (per_r == `CONV_PERIODS - 4'h1) begin
						state_nxt = ST_IDLE;
						result_nxt = sar_nxt;
						ctl0_nxt[`BIT_START] = 1'b0;
						flag_nxt  = 1'b1;
					end
				end
			end
			ST_ABORT: begin
				// No start is taken while settling, so busy never lies
				ctl0_nxt[`BIT_START] = 1'b0;
				if (tick) begin
					per_nxt = per_r + 4'h1;
					if (per_r == `ABORT_PERIODS - 4'h1) begin
						state_nxt = ST_IDLE;
					end
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Read mux, with justified result and zero for unused bits; loaded in
	// the wait cycle so the data already stand when waitrequest drops
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (i_read && !resp_r) begin
			unique case (i_address)
				`OFF_CONTROL_0:   rdata_nxt[7:0] = ctl0_r;
				`OFF_CONTROL_1:   rdata_nxt[6:4] = clk_sel_r;
				`OFF_RESULT_HIGH: rdata_nxt[7:0] = ctl0_r[`BIT_JUSTIFY]
					? {6'h00, result_r[9:8]}
					: result_r[9:2];
				`OFF_RESULT_LOW:  rdata_nxt[7:0] = ctl0_r[`BIT_JUSTIFY]
					? result_r[7:0]
					: {result_r[1:0], 6'h00};
				`OFF_IRQ_STATUS:  rdata_nxt[0] = flag_r;
				`OFF_IRQ_MASK:    rdata_nxt[0] = mask_r;
				default:          rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// State registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_r   <= ST_IDLE;
			ctl0_r    <= `CONTROL_0_RST;
			clk_sel_r <= `CONTROL_1_RST;
			result_r  <= 10'h000;
			sar_r     <= 10'h000;
			per_r     <= 4'h0;
			flag_r    <= 1'b0;
			mask_r    <= 1'b0;
			resp_r    <= 1'b0;
			rdata_r   <= 32'h0000_0000;
		end else begin
			state_r   <= state_nxt;
			ctl0_r    <= ctl0_nxt;
			clk_sel_r <= clk_sel_nxt;
			result_r  <= result_nxt;
			sar_r     <= sar_nxt;
			per_r     <= per_nxt;
			flag_r    <= flag_nxt;
			mask_r    <= mask_nxt;
			resp_r    <= resp_nxt;
			rdata_r   <= rdata_nxt;
		end
	end

	// Outputs to the sampler; idle with enable set means acquiring
	always_comb begin
		o_analog.enable    = ctl0_r[`BIT_ENABLE];
		o_analog.reference = ctl0_r[`BIT_REFERENCE];
		o_analog.channel   = ctl0_r[`CHAN_HI:`CHAN_LO];
		o_analog.sample    = ctl0_r[`BIT_ENABLE] && state_r == ST_IDLE;
		o_analog.hold      = state_r == ST_CONVERT;
	end
	assign o_dac_code = sar_r;
	assign o_readdata = rdata_r;
	assign o_irq      = flag_r & mask_r;

	// Completion clears the busy bit and raises the flag together
	a_done_sets_flag: assert property (
		@(posedge i_clk) disable iff (i_rst)
		state_r == ST_CONVERT && state_nxt == ST_IDLE |=>
		flag_r && !ctl0_r[`BIT_START])
		else $error("completion did not set flag or clear start");

	a_irq_level: assert property (
		@(posedge i_clk) disable iff (i_rst)
		o_irq == (flag_r && mask_r))
		else $error("interrupt output wrong");

	// Control 1 readback keeps its unused bits low as well
	a_reserved_zero: assert property (
		@(posedge i_clk) disable iff (i_rst)
		!ctl0_r[5] && rdata_r[31:8] == 24'h000000
		&& (!rd_acc || i_address != `OFF_CONTROL_1
		|| (!rdata_r[7] && rdata_r[3:0] == 4'h0)))
		else $error("unimplemented bit not zero");

	a_abort_keeps: assert property (
		@(posedge i_clk) disable iff (i_rst)
		state_r == ST_ABORT |=> $stable(result_r) || $past(wr_acc))
		else $error("abort changed result");

	a_off_no_run: assert property (
		@(posedge i_clk) disable iff (i_rst)
		!ctl0_r[`BIT_ENABLE] |-> !ctl0_r[`BIT_START] && !o_analog.sample)
		else $error("converter runs while disabled");

	a_start_busy: assert property (
		@(posedge i_clk) disable iff (i_rst)
		state_r == ST_IDLE && start_req |=>
		state_r == ST_CONVERT && ctl0_r[`BIT_START])
		else $error("start did not begin conversion");

	a_eleven_periods: assert property (
		@(posedge i_clk) disable iff (i_rst)
		state_r == ST_CONVERT && state_nxt == ST_IDLE |->
		per_r == 4'hA && tick)
		else $error("conversion length wrong");

	// Read data stand in the cycle in which the bus takes them
	a_right_high: assert property (
		@(posedge i_clk) disable iff (i_rst)
		rd_acc && i_address == `OFF_RESULT_HIGH && ctl0_r[`BIT_JUSTIFY] |->
		o_readdata[7:2] == 6'h00)
		else $error("right justified high byte wrong");

	a_left_low: assert property (
		@(posedge i_clk) disable iff (i_rst)
		rd_acc && i_address == `OFF_RESULT_LOW && !ctl0_r[`BIT_JUSTIFY] |->
		o_readdata[5:0] == 6'h00)
		else $error("left justified low byte wrong");

	// A new conversion always opens with the mid-scale trial
	a_first_trial: assert property (
		@(posedge i_clk) disable iff (i_rst)
		state_r == ST_IDLE && start_req |=> o_dac_code == 10'h200)
		else $error("first trial code wrong");

	// The flag only ever rises out of a finished conversion
	a_flag_from_done: assert property (
		@(posedge i_clk) disable iff (i_rst)
		$rose(flag_r) |-> $past(state_r) == ST_CONVERT)
		else $error("flag set outside completion");

	// Stopping early leaves the stored result alone and drops busy
	a_abort_entry: assert property (
		@(posedge i_clk) disable iff (i_rst)
		state_r == ST_CONVERT && state_nxt == ST_ABORT |=>
		$stable(result_r) && !ctl0_r[`BIT_START])
		else $error("abort updated result or left busy set");

	// Settling needs a second period after the first tick
	a_abort_two: assert property (
		@(posedge i_clk) disable iff (i_rst)
		state_r == ST_ABORT && tick && per_r == 4'h0 |=>
		state_r == ST_ABORT)
		else $error("abort settle shorter than two periods");

endmodule : adc_sequencer_regs

/* File: adc_tick_gen.sv */
`timescale 1ns/1ps
`include "adc_seq_defs.svh"

// Produces one pulse per bit conversion period from the chosen source
module adc_tick_gen (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Control
	input  wire logic       i_run,
	input  wire logic [2:0] i_clk_sel,
	// Tick out
	output logic            o_tick
);

	logic [6:0] cnt_r;
	logic [6:0] cnt_nxt;
	logic [6:0] limit;

	// Decode the clock select code to a divide ratio
	function automatic logic [6:0] div_of(input logic [2:0] sel);
		unique case (sel)
			3'h0: div_of = 7'h02;
			3'h4: div_of = 7'h04;
			3'h1: div_of = 7'h08;
			3'h5: div_of = 7'h10;
			3'h2: div_of = 7'h20;
			3'h6: div_of = 7'h40;
			default: div_of = 7'(`RC_DIV); // Stand-in for the RC oscillator
		endcase
	endfunction : div_of

	// Count up to the divide ratio while running
	always_comb begin
		limit   = div_of(i_clk_sel);
		cnt_nxt = cnt_r;
		o_tick  = 1'b0;
		if (!i_run) begin
			cnt_nxt = 7'h00;
		end else if (cnt_r == limit - 7'h01) begin
			cnt_nxt = 7'h00;
			o_tick  = 1'b1;
		end else begin
			cnt_nxt = cnt_r + 7'h01;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_r <= 7'h00;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule : adc_tick_gen

/* File: analog_front_model.sv */
`timescale 1ns/1ps

// Sampler and comparator seen from the sequencer side
module analog_front_model (
	// Clock
	input  wire logic                i_clk,
	// From the sequencer
	input  adc_seq_pkg::analog_ctl_t i_analog,
	input  wire logic [9:0]          i_dac_code,
	// Held input level, 1024 steps
	input  wire logic [9:0]          i_level,
	// Decision out
	output logic                     o_cmp_out
);
	logic toggle_r = 1'b0;

	// Idle comparator chatters so a stale decision is never reused
	always @(posedge i_clk) begin
		toggle_r <= ~toggle_r;
	end

	// Decision is only meaningful while powered and holding
	assign o_cmp_out = (i_analog.enable && i_analog.hold) ?
		(i_level >= i_dac_code) : toggle_r;
endmodule : analog_front_model

/* File: tb_adc_sequencer_regs.sv */
`timescale 1ns/1ps
`include "adc_seq_defs.svh"

module tb_adc_sequencer_regs;
	import adc_seq_pkg::*;
	logic        i_clk, i_rst, i_read, i_write, i_cmp_out;
	logic        o_waitrequest, o_irq, ok;
	logic [3:0]  i_address;
	logic [31:0] i_writedata, o_readdata, q, hi, lo;
	logic [9:0]  o_dac_code, level;
	analog_ctl_t o_analog;
	int          failures, compares, cyc, n, div[8];
	// The model settles at once, so any short acquisition wait will do
	localparam int ACQ_CYCLES = 8;

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
$display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end

	adc_sequencer_regs u_dut (.i_clk(i_clk), .i_rst(i_rst),
		.i_address(i_address), .i_read(i_read), .i_write(i_write),
		.i_writedata(i_writedata), .o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest), .i_cmp_out(i_cmp_out),
		.o_analog(o_analog), .o_dac_code(o_dac_code), .o_irq(o_irq));
	analog_front_model u_afe (.i_clk(i_clk), .i_analog(o_analog),
		.i_dac_code(o_dac_code), .i_level(level), .o_cmp_out(i_cmp_out));

	// Free-running clock
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	// Hang guard, well above the longest expected run
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 60000) begin
			failures++;
			conclude();
		end
	end

	task conclude;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	// One Avalon transfer, held until waitrequest is seen low
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_address   <= a;
		i_read      <= ~wr;
		i_write     <= wr;
		i_writedata <= d;
		do begin
			@(posedge i_clk);
		end while (o_waitrequest !== 1'b0);
		q = o_readdata;
		i_read  <= 1'b0;
		i_write <= 1'b0;
		// Let the edge that took the request settle before callers look
		@(negedge i_clk);
	endtask : bus

	// Enable, wait out acquisition, start, then poll until hardware drops it
	task convert(input logic [7:0] c0);
		bus(1'b1, `OFF_CONTROL_0, {24'h0, c0 & 8'hFD});
		repeat (ACQ_CYCLES) @(posedge i_clk);
		bus(1'b1, `OFF_CONTROL_0, {24'h0, c0});
		bus(1'b0, `OFF_CONTROL_0, 32'h0);
		`CHK(q[1], 1'b1)
		repeat (400) begin
			bus(1'b0, `OFF_CONTROL_0, 32'h0);
			if (q[1] === 1'b0)
				break;
		end
		`CHK(q[1], 1'b0)
		bus(1'b0, `OFF_RESULT_HIGH, 32'h0);
		hi = q;
		bus(1'b0, `OFF_RESULT_LOW, 32'h0);
		lo = q;
	endtask : convert

	task t_regs;
		bus(1'b0, `OFF_CONTROL_1, 32'h0);
		`CHK(q, 32'h0)
		bus(1'b1, `OFF_CONTROL_0, 32'hFD);
		bus(1'b0, `OFF_CONTROL_0, 32'h0);
		`CHK(q, 32'hDD)
		bus(1'b1, `OFF_CONTROL_1, 32'hFF);
		bus(1'b0, `OFF_CONTROL_1, 32'h0);
		`CHK(q, 32'h70)
		bus(1'b0, 4'h7, 32'h0);
		`CHK(q, 32'h0)
		for (int ch = 0; ch < 7; ch++) begin
			bus(1'b1, `OFF_CONTROL_0, {24'h0, 3'h2, ch[2:0], 2'h1});
			`CHK(o_analog.channel, ch[2:0])
			`CHK(o_analog.reference, 1'b1)
		end
		bus(1'b1, `OFF_CONTROL_0, 32'h01);
		`CHK(o_analog.reference, 1'b0)
		$display("test regs done");
	endtask : t_regs

	task t_format;
		bus(1'b1, `OFF_CONTROL_1, 32'h0);
		level = 10'h2A5;
		convert(8'h83);
		`CHK(hi, {30'h0, level[9:8]})
		`CHK(lo, {24'h0, level[7:0]})
		level = 10'h1CB;
		convert(8'h03);
		`CHK(hi, {24'h0, level[9:2]})
		`CHK(lo, {24'h0, level[1:0], 6'h00})
		bus(1'b0, `OFF_IRQ_STATUS, 32'h0);
		`CHK(q[0], 1'b1)
		$display("test format done");
	endtask : t_format

	task t_irq;
		bus(1'b1, `OFF_IRQ_STATUS, 32'h1);
		bus(1'b0, `OFF_IRQ_STATUS, 32'h0);
		`CHK(q[0], 1'b0)
		bus(1'b1, `OFF_IRQ_MASK, 32'h1);
		`CHK(o_irq, 1'b0)
		convert(8'h83);
		`CHK(o_irq, 1'b1)
		bus(1'b1, `OFF_IRQ_MASK, 32'h0);
		`CHK(o_irq, 1'b0)
		bus(1'b1, `OFF_IRQ_MASK, 32'h1);
		`CHK(o_irq, 1'b1)
		bus(1'b1, `OFF_IRQ_STATUS, 32'h1);
		`CHK(o_irq, 1'b0)
		bus(1'b0, `OFF_IRQ_MASK, 32'h0);
		`CHK(q[0], 1'b1)
		$display("test irq done");
	endtask : t_irq

	// Early stop on the slowest divide must leave the result alone
	task t_abort;
		bus(1'b1, `OFF_CONTROL_1, 32'h60);
		level = 10'h0F0;
		bus(1'b1, `OFF_CONTROL_0, 32'h83);
		repeat (100) @(posedge i_clk);
		bus(1'b1, `OFF_CONTROL_0, 32'h81);
		bus(1'b0, `OFF_CONTROL_0, 32'h0);
		`CHK(q[1], 1'b0)
		`CHK(o_analog.sample, 1'b0)
		repeat (300) @(posedge i_clk);
		`CHK(o_analog.hold, 1'b0)
		`CHK(o_analog.sample, 1'b1)
		bus(1'b0, `OFF_RESULT_LOW, 32'h0);
		`CHK(q, lo)
		bus(1'b1, `OFF_CONTROL_0, 32'h00);
		`CHK(o_analog.enable, 1'b0)
		bus(1'b1, `OFF_CONTROL_0, 32'h02);
		bus(1'b0, `OFF_CONTROL_0, 32'h0);
		`CHK(q[1], 1'b0)
		$display("test abort done");
	endtask : t_abort

	// Hold lasts eleven periods from the edge that took the start
	task t_clocks;
		div = '{2, 8, 32, 50, 4, 16, 64, 50};
		for (int c = 0; c < 8; c++) begin
			bus(1'b1, `OFF_CONTROL_1, {25'h0, c[2:0], 4'h0});
			bus(1'b1, `OFF_CONTROL_0, 32'h83);
			n = 0;
			while (o_analog.hold !== 1'b0 && n < 2000) begin
				@(posedge i_clk);
				n++;
			end
			ok = (n == 11 * div[c] + 1);
			`CHK(ok, 1'b1)
		end
		$display("test clocks done");
	endtask : t_clocks

	// Main sequence
	initial begin
		i_rst = 1'b1;
		i_read = 1'b0;
		i_write = 1'b0;
		i_address = 4'h0;
		i_writedata = 32'h0;
		level = 10'h0;
		repeat (20) @(posedge i_clk);
		i_rst <= 1'b0;
		t_regs();
		t_format();
		t_irq();
		t_abort();
		t_clocks();
		conclude();
	end
endmodule : tb_adc_sequencer_regs
